// ===== verilog/lsp_regs.vh
// Purpose: Offsets, field positions, reset values and timing counts for the port groups
// Assumes: AXI4-Lite byte addresses are four times the register index
// Notes: Summary of operation
//
// Summary of operation
// RULE1: Group 8 has three pins, each GPIO or LCD segment output.
// RULE2: Software clears input enable and disables output before segment use.
// RULE3: With segment off, the two enable bits alone decide drive and sampling; the code also turns both off while the group gate bit is set.
// RULE4: Control bit 3 gates groups 0 to 8 to save power.
// RULE5: Output enable bit 1 disables driver; implemented bits reset to one.
// RULE6: Input enable bit 1 enables sampling; bits reset to zero.
// RULE7: Group 8 output data bits 2 to 0 reset to one; upper bits ignored.
// RULE8: Enabled input data tracks the live pad whatever the pin function; the code holds input data while a segment is selected.
// RULE9: Software keeps inputs disabled when unneeded to save power.
// RULE10: Group 9 has eight pins, each GPIO or special function.
// RULE11: Group 9 GPIO runs in fast mode, 200 kbps at 13.1072 MHz.
// RULE12: A one second pulse on group 9 pin 1 enables its input automatically.
// RULE13: Each group 9 pin function comes from its own select bit.
// RULE14: Control bit 6 puts serial data on pin 1 and clock on pin 2.
// RULE15: In serial mode pin 1 output follows serial data, input enabled by software.
// RULE16: In serial mode pin 2 output enable is forced active.
// RULE17: Group 9 pin 0 may also be an LCD segment output.
// RULE18: Control bit 4 gates group 9 control logic.
// RULE19: Group 9 registers sit at indices 0xa4 to 0xa7 with given resets.
// RULE20: Select bit 0 keeps fast GPIO, 1 selects the special function.
// RULE21: While gated, input data holds and pad drivers stay disabled.
`ifndef LSP_REGS_VH
`define LSP_REGS_VH
// Register indices; byte address is index times four
`define LSP_IDX_G9_OE 14'h00a4
`define LSP_IDX_G9_IE 14'h00a5
`define LSP_IDX_G9_OD 14'h00a6
`define LSP_IDX_G9_ID 14'h00a7
`define LSP_IDX_G9_FS 14'h00ad
`define LSP_IDX_G8_OE 14'h28d9
`define LSP_IDX_G8_IE 14'h28da
`define LSP_IDX_G8_OD 14'h28db
`define LSP_IDX_G8_ID 14'h28dc
`define LSP_IDX_PWR 14'h2d00
// Control register fields
`define LSP_LOW_GATE_BIT 3
`define LSP_G9_GATE_BIT 4
`define LSP_SERIAL_BIT 6
// Group 9 segment select (own register, index 0xae)
`define LSP_IDX_SEG 14'h00ae
// Reset values
`define LSP_RST_OE 8'hff
`define LSP_RST_IE 8'h00
`define LSP_RST_OD 8'hff
`define LSP_RST_FS 8'h00
`define LSP_RST_PWR 8'h00
// Reference pulse length
`define LSP_CLK_HZ 100000000
`define LSP_REF_PULSE_S 1
`define LSP_REF_TOL_CYC 1000
`endif

// ===== verilog/lsp_pin.v
// Purpose: One pad slice: drive, enable and input capture for a single pin
// Assumes: Pad input synchronous to clk
// Notes: Input data holds while sampling disabled or group gated
`timescale 1ns/1ns
module lsp_pin (
   input wire clk,
   input wire rst,
   input wire oe_n,
   input wire ie,
   input wire od,
   input wire seg_sel,
   input wire seg_val,
   input wire gate,
   input wire pad_in,
   output reg pad_out,
   output reg pad_oe,
   output reg id_r
);
   always @(posedge clk) begin
      if (rst) begin
         pad_out <= 1'b0;
         pad_oe <= 1'b0;
         id_r <= 1'b0;
      end else begin
         // Segment owns the pad unless gated; else enables and gate decide
         pad_out <= seg_sel ? seg_val : od; // RULE3
         pad_oe <= ~gate & (seg_sel | ~oe_n); // RULE5 RULE21
         if (ie & ~gate & ~seg_sel) begin
            id_r <= pad_in; // RULE8 RULE6
         end
      end
   end
endmodule

// ===== verilog/lsp_top.v
// Purpose: GPIO logic of port groups 8 and 9 behind an AXI4-Lite slave
// Assumes: Single clock, synchronous active-high reset
// Assumes: Pads, segment lines and peripheral lines already synchronous to clk
// Notes: Special-function peripherals and LCD driver sit outside
// Notes: Write answer three cycles after valid, read answer two
// Notes: Input data words accept writes but ignore them
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ns
`include "lsp_regs.vh"
module lsp_top #(
   parameter REF_CYCLES = `LSP_REF_PULSE_S * `LSP_CLK_HZ,
   parameter REF_TOL = `LSP_REF_TOL_CYC
) (
   input wire clk,
   input wire rst,
   input wire [15:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [15:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire [2:0] g8_pad_in,
   output wire [2:0] g8_pad_out,
   output wire [2:0] g8_pad_oe,
   input wire [2:0] g8_seg_sel,
   input wire [2:0] g8_seg_val,
   input wire [7:0] g9_pad_in,
   output wire [7:0] g9_pad_out,
   output wire [7:0] g9_pad_oe,
   input wire [7:0] g9_sf_out,
   input wire [7:0] g9_sf_oe,
   input wire g9_seg_val,
   input wire serial_data_out,
   input wire serial_clk_out,
   output reg [7:0] g9_function_sel,
   output reg serial_mode,
   output reg low_groups_gated
);
   localparam [31:0] CNT_MAX = REF_CYCLES + REF_TOL;
   localparam S_IDLE = 2'd0;
   localparam S_HIGH = 2'd1;

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   reg [2:0] g8_oe_r, g8_ie_r, g8_od_r;
   reg [7:0] g9_oe_r, g9_ie_r, g9_od_r, pwr_r;
   reg g9_seg_r;
   wire [2:0] g8_id;
   wire [7:0] g9_id;
   wire low_gate = pwr_r[`LSP_LOW_GATE_BIT];
   wire g9_gate = pwr_r[`LSP_G9_GATE_BIT];
   wire ser = pwr_r[`LSP_SERIAL_BIT];

   // ------------------------------------------------------------
   // AXI4-Lite write channel
   // ------------------------------------------------------------
   reg aw_held_r, w_held_r;
   reg [13:0] aw_idx_r;
   reg [7:0] wd_r;
   reg ws_r;
   reg auto_ie_r;
   reg wr_ok;

   always @* begin
      case (aw_idx_r)
         `LSP_IDX_G9_OE, `LSP_IDX_G9_IE, `LSP_IDX_G9_OD, `LSP_IDX_G9_ID,
         `LSP_IDX_G9_FS, `LSP_IDX_SEG, `LSP_IDX_G8_OE, `LSP_IDX_G8_IE,
         `LSP_IDX_G8_OD, `LSP_IDX_G8_ID, `LSP_IDX_PWR: wr_ok = 1'b1;
         default: wr_ok = 1'b0;
      endcase
   end

   // ------------------------------------------------------------
   // Register next values
   // ------------------------------------------------------------
   wire wr_fire = aw_held_r & w_held_r & ~s_axi_bvalid & ws_r;
   reg [2:0] g8_oe_nxt, g8_ie_nxt, g8_od_nxt;
   reg [7:0] g9_oe_nxt, g9_ie_nxt, g9_od_nxt, g9_fs_nxt, pwr_nxt;
   reg g9_seg_nxt;

   always @* begin
      g8_oe_nxt = g8_oe_r;
      g8_ie_nxt = g8_ie_r;
      g8_od_nxt = g8_od_r;
      g9_oe_nxt = g9_oe_r;
      g9_ie_nxt = g9_ie_r;
      g9_od_nxt = g9_od_r;
      g9_fs_nxt = g9_function_sel;
      pwr_nxt = pwr_r;
      g9_seg_nxt = g9_seg_r;
      // Input data words are sampled pad images, so writes there are dropped
      if (wr_fire) begin
         case (aw_idx_r)
            `LSP_IDX_G8_OE: g8_oe_nxt = wd_r[2:0]; // RULE1
            `LSP_IDX_G8_IE: g8_ie_nxt = wd_r[2:0];
            `LSP_IDX_G8_OD: g8_od_nxt = wd_r[2:0]; // RULE7
            `LSP_IDX_G9_OE: g9_oe_nxt = wd_r;
            `LSP_IDX_G9_IE: g9_ie_nxt = wd_r;
            `LSP_IDX_G9_OD: g9_od_nxt = wd_r;
            `LSP_IDX_G9_FS: g9_fs_nxt = wd_r; // RULE13 RULE20
            `LSP_IDX_SEG: g9_seg_nxt = wd_r[0]; // RULE17
            `LSP_IDX_PWR: pwr_nxt = wd_r;
            default: ;
         endcase
      end
      // Hardware set wins over a software write in the same cycle
      if (auto_ie_r) begin
         g9_ie_nxt[1] = 1'b1; // RULE12
      end
   end

   always @(posedge clk) begin
      if (rst) begin
         aw_held_r <= 1'b0;
         w_held_r <= 1'b0;
         aw_idx_r <= 14'h0000;
         wd_r <= 8'h00;
         ws_r <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
         g8_oe_r <= 3'h7; // RULE5
         g8_ie_r <= 3'h0; // RULE6
         g8_od_r <= 3'h7; // RULE7
         g9_oe_r <= `LSP_RST_OE; // RULE19
         g9_ie_r <= `LSP_RST_IE; // RULE19
         g9_od_r <= `LSP_RST_OD; // RULE19
         g9_function_sel <= `LSP_RST_FS;
         pwr_r <= `LSP_RST_PWR;
         g9_seg_r <= 1'b0;
      end else begin
         // Ready pulses for one cycle when the channel is taken
         s_axi_awready <= s_axi_awvalid & ~aw_held_r & ~s_axi_awready & ~s_axi_bvalid;
         s_axi_wready <= s_axi_wvalid & ~w_held_r & ~s_axi_wready & ~s_axi_bvalid;
         if (s_axi_awvalid & s_axi_awready) begin
            aw_held_r <= 1'b1;
            aw_idx_r <= s_axi_awaddr[15:2];
         end
         if (s_axi_wvalid & s_axi_wready) begin
            w_held_r <= 1'b1;
            wd_r <= s_axi_wdata[7:0];
            ws_r <= s_axi_wstrb[0];
         end
         if (aw_held_r & w_held_r & ~s_axi_bvalid) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? 2'h0 : 2'h2;
         end else if (s_axi_bvalid & s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         g8_oe_r <= g8_oe_nxt;
         g8_ie_r <= g8_ie_nxt;
         g8_od_r <= g8_od_nxt;
         g9_oe_r <= g9_oe_nxt;
         g9_ie_r <= g9_ie_nxt;
         g9_od_r <= g9_od_nxt;
         g9_function_sel <= g9_fs_nxt;
         pwr_r <= pwr_nxt;
         g9_seg_r <= g9_seg_nxt;
      end
   end

   // ------------------------------------------------------------
   // AXI4-Lite read channel
   // ------------------------------------------------------------
   reg [7:0] rd_mux;
   reg rd_ok;
   always @* begin
      rd_ok = 1'b1;
      case (s_axi_araddr[15:2])
         `LSP_IDX_G8_OE: rd_mux = {5'h00, g8_oe_r};
         `LSP_IDX_G8_IE: rd_mux = {5'h00, g8_ie_r};
         `LSP_IDX_G8_OD: rd_mux = {5'h00, g8_od_r};
         `LSP_IDX_G8_ID: rd_mux = {5'h00, g8_id};
         `LSP_IDX_G9_OE: rd_mux = g9_oe_r;
         `LSP_IDX_G9_IE: rd_mux = g9_ie_r;
         `LSP_IDX_G9_OD: rd_mux = g9_od_r;
         `LSP_IDX_G9_ID: rd_mux = g9_id;
         `LSP_IDX_G9_FS: rd_mux = g9_function_sel;
         `LSP_IDX_SEG: rd_mux = {7'h00, g9_seg_r};
         `LSP_IDX_PWR: rd_mux = pwr_r;
         default: begin
            rd_mux = 8'h00;
            rd_ok = 1'b0;
         end
      endcase
   end

   always @(posedge clk) begin
      if (rst) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= 2'h0;
      end else begin
         s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
         if (s_axi_arvalid & s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h000000, rd_mux};
            s_axi_rresp <= rd_ok ? 2'h0 : 2'h2;
         end else if (s_axi_rvalid & s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // Reference pulse detector on group 9 pin 1
   // ------------------------------------------------------------
   // Watches the raw pad so the input can wake itself up
   reg [1:0] ref_st_r, ref_st_nxt;
   reg [31:0] ref_cnt_r, ref_cnt_nxt;
   reg ref_prev_r;
   reg auto_ie_nxt;

   always @* begin
      ref_st_nxt = ref_st_r;
      ref_cnt_nxt = ref_cnt_r;
      auto_ie_nxt = 1'b0;
      case (ref_st_r)
         S_IDLE: begin
            ref_cnt_nxt = 32'h00000000;
            if (g9_pad_in[1] & ~ref_prev_r) begin
               ref_st_nxt = S_HIGH;
            end
         end
         S_HIGH: begin
            // Counter holds the high width seen so far less one
            if (~g9_pad_in[1]) begin
               // Accept a width within REF_TOL cycles of REF_CYCLES
               if (ref_cnt_r + 32'h00000001 + REF_TOL >= REF_CYCLES) begin
                  auto_ie_nxt = 1'b1; // RULE12
               end
               ref_st_nxt = S_IDLE;
            end else if (ref_cnt_r + 32'h00000001 >= CNT_MAX) begin
               // Already too wide: give up rather than let the counter wrap
               ref_st_nxt = S_IDLE;
            end else begin
               ref_cnt_nxt = ref_cnt_r + 32'h00000001;
            end
         end
         default: ref_st_nxt = S_IDLE;
      endcase
   end

   always @(posedge clk) begin
      if (rst) begin
         ref_st_r <= S_IDLE;
         ref_cnt_r <= 32'h00000000;
         ref_prev_r <= 1'b0;
         auto_ie_r <= 1'b0;
      end else begin
         ref_st_r <= ref_st_nxt;
         ref_cnt_r <= ref_cnt_nxt;
         ref_prev_r <= g9_pad_in[1];
         auto_ie_r <= auto_ie_nxt;
      end
   end

   // ------------------------------------------------------------
   // Pin muxing
   // ------------------------------------------------------------
   reg [7:0] g9_od_mux, g9_oen_mux;
   always @* begin
      // Fast GPIO: pads follow registers every cycle
      g9_od_mux = g9_od_r; // RULE11
      g9_oen_mux = g9_oe_r;
      g9_od_mux = (g9_function_sel & g9_sf_out) | (~g9_function_sel & g9_od_r); // RULE20
      g9_oen_mux = (g9_function_sel & ~g9_sf_oe) | (~g9_function_sel & g9_oe_r); // RULE10
      if (ser) begin
         g9_od_mux[1] = serial_data_out; // RULE14 RULE15
         g9_od_mux[2] = serial_clk_out; // RULE14
         g9_oen_mux[2] = 1'b0; // RULE16
      end
   end

   // ------------------------------------------------------------
   // Gating and mode outputs
   // ------------------------------------------------------------
   always @(posedge clk) begin
      if (rst) begin
         serial_mode <= 1'b0;
         low_groups_gated <= 1'b0;
      end else begin
         serial_mode <= ser;
         low_groups_gated <= low_gate; // RULE4
      end
   end

   // ------------------------------------------------------------
   // Pin slices
   // ------------------------------------------------------------
   genvar i;
   generate
      for (i = 0; i < 3; i = i + 1) begin : g8
         lsp_pin lsp_pin_inst (
            .clk(clk),
            .rst(rst),
            .oe_n(g8_oe_r[i]),
            .ie(g8_ie_r[i]),
            .od(g8_od_r[i]),
            .seg_sel(g8_seg_sel[i]), // RULE1
            .seg_val(g8_seg_val[i]),
            .gate(low_gate), // RULE4
            .pad_in(g8_pad_in[i]),
            .pad_out(g8_pad_out[i]),
            .pad_oe(g8_pad_oe[i]),
            .id_r(g8_id[i])
         );
      end
      for (i = 0; i < 8; i = i + 1) begin : g9
         lsp_pin lsp_pin_inst (
            .clk(clk),
            .rst(rst),
            .oe_n(g9_oen_mux[i]),
            .ie(g9_ie_r[i]),
            .od(g9_od_mux[i]),
            .seg_sel((i == 0) ? g9_seg_r : 1'b0), // RULE17
            .seg_val(g9_seg_val),
            .gate(g9_gate), // RULE18
            .pad_in(g9_pad_in[i]),
            .pad_out(g9_pad_out[i]),
            .pad_oe(g9_pad_oe[i]),
            .id_r(g9_id[i])
         );
      end
   endgenerate
endmodule

// ===== testbench/lsp_pads.sv
// Purpose: Pad model for groups 8 and 9
// Assumes: Undriven pad takes the level the bench sets
// Notes: A driven pad reads back its own drive
`timescale 1ns/1ns
module lsp_pads (
   input wire [10:0] pad_out,
   input wire [10:0] pad_oe,
   input wire [10:0] ext,
   output wire [10:0] pad_in
);
   // --------
   // Pad level
   // --------
   assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext);
endmodule

// ===== testbench/lsp_top_asserts.sv
// Purpose: Port checks for the port group block
// Assumes: One clock, sync active-high reset
// Notes: Sees top ports only
`timescale 1ns/1ns
module lsp_top_asserts (
   input wire clk,
   input wire rst,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire s_axi_rvalid,
   input wire s_axi_rready,
   input wire [31:0] s_axi_rdata,
   input wire s_axi_awready,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire [1:0] s_axi_bresp,
   input wire [2:0] g8_pad_oe,
   input wire [7:0] g9_pad_out,
   input wire [7:0] g9_sf_out,
   input wire [7:0] g9_function_sel,
   input wire serial_mode,
   input wire serial_data_out,
   input wire low_groups_gated
);
   // --------
   // Checks
   // --------
   default clocking dc @(posedge clk); endclocking
   default disable iff (rst);
   rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("rvalid late");
   rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read dropped");
   rd_width_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
      else $error("rdata upper set");
   wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write answer dropped");
   aw_pulse_a: assert property (s_axi_awready |=> !s_axi_awready)
      else $error("awready held");
   low_gate_a: assert property (low_groups_gated && $past(low_groups_gated) |-> g8_pad_oe == 3'h0)
      else $error("gated pad driven");
   sf_follow_a: assert property ($past(g9_function_sel[7]) |-> g9_pad_out[7] == $past(g9_sf_out[7]))
      else $error("function output lost");
   serial_data_a: assert property (serial_mode |-> g9_pad_out[1] == $past(serial_data_out))
      else $error("serial data lost");
endmodule
bind lsp_top lsp_top_asserts lsp_top_asserts_inst (.clk, .rst, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_awready, .s_axi_bvalid, .s_axi_bready,
   .s_axi_bresp, .g8_pad_oe, .g9_pad_out, .g9_sf_out, .g9_function_sel, .serial_mode,
   .serial_data_out, .low_groups_gated);

// ===== testbench/lsp_top_test.sv
// Purpose: Self-checking bench for the port group block
// Assumes: Byte address is index times four
// Notes: Short reference pulse count keeps the run brief
`timescale 1ns/1ns
`include "lsp_regs.vh"
module lsp_top_test;
   reg clk = 1'b0;
   reg rst = 1'b1;
   reg [15:0] s_axi_awaddr = 16'h0;
   reg [15:0] s_axi_araddr = 16'h0;
   reg [31:0] s_axi_wdata = 32'h0;
   reg [3:0] s_axi_wstrb = 4'hf;
   reg s_axi_awvalid = 1'b0;
   reg s_axi_wvalid = 1'b0;
   reg s_axi_bready = 1'b0;
   reg s_axi_arvalid = 1'b0;
   reg s_axi_rready = 1'b0;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   reg [2:0] g8_ext = 3'h0;
   reg [7:0] g9_ext = 8'h0;
   wire [10:0] pin;
   wire [2:0] g8_pad_in = pin[2:0];
   wire [7:0] g9_pad_in = pin[10:3];
   wire [2:0] g8_pad_out, g8_pad_oe;
   wire [7:0] g9_pad_out, g9_pad_oe, g9_function_sel;
   reg [2:0] g8_seg_sel = 3'h0;
   reg [2:0] g8_seg_val = 3'h0;
   reg [7:0] g9_sf_out = 8'h0;
   reg [7:0] g9_sf_oe = 8'h0;
   reg g9_seg_val = 1'b0;
   reg serial_data_out = 1'b0;
   reg serial_clk_out = 1'b0;
   wire serial_mode, low_groups_gated;
   integer err_total = 0;
   integer compares = 0;
   integer cyc = 0;
   integer w;
   reg [31:0] rd;
   reg [31:0] keep;
   reg [1:0] rsp;
   // --------
   // Block and pads
   // --------
   lsp_top #(.REF_CYCLES(50), .REF_TOL(2)) lsp_top_inst (.clk, .rst, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .g8_pad_in, .g8_pad_out, .g8_pad_oe, .g8_seg_sel, .g8_seg_val,
      .g9_pad_in, .g9_pad_out, .g9_pad_oe, .g9_sf_out, .g9_sf_oe, .g9_seg_val,
      .serial_data_out, .serial_clk_out, .g9_function_sel, .serial_mode, .low_groups_gated);
   lsp_pads lsp_pads_inst (.pad_out({g9_pad_out, g8_pad_out}), .pad_oe({g9_pad_oe, g8_pad_oe}),
      .ext({g9_ext, g8_ext}), .pad_in(pin));
   always #5 clk = ~clk;
   // --------
   // Shared tasks
   // --------
   task chk(input [31:0] seen, input [31:0] exp);
      begin
         compares = compares + 1;
         if (seen !== exp) begin
            err_total = err_total + 1;
            $display("Error t=%0t seen %h expected %h", $time, seen, exp);
         end
      end
   endtask
   task wr(input [13:0] idx, input [7:0] d);
      begin
         @(posedge clk);
         s_axi_awaddr <= {idx, 2'b00};
         s_axi_wdata <= {24'h0, d};
         s_axi_awvalid <= 1'b1;
         s_axi_wvalid <= 1'b1;
         s_axi_bready <= 1'b1;
         @(posedge clk);
         while (!s_axi_bvalid) begin
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            @(posedge clk);
         end
         s_axi_bready <= 1'b0;
         rsp = s_axi_bresp;
      end
   endtask
   task rdr(input [13:0] idx);
      begin
         @(posedge clk);
         s_axi_araddr <= {idx, 2'b00};
         s_axi_arvalid <= 1'b1;
         s_axi_rready <= 1'b1;
         @(posedge clk);
         while (!s_axi_rvalid) begin
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            @(posedge clk);
         end
         s_axi_rready <= 1'b0;
         rd = s_axi_rdata;
         rsp = s_axi_rresp;
      end
   endtask
   task settle;
      begin
         repeat (3) @(posedge clk);
         #1;
      end
   endtask
   // --------
   // Scenarios
   // --------
   task t_reset;
      begin
         chk(g9_pad_oe, 8'h0);
         rdr(`LSP_IDX_G9_OE);
         chk(rd, 32'hff);
         rdr(`LSP_IDX_G9_IE);
         chk(rd, 32'h0);
         rdr(`LSP_IDX_G9_OD);
         chk(rd, 32'hff);
         rdr(`LSP_IDX_G8_OE);
         chk(rd[2:0], 3'h7);
         rdr(`LSP_IDX_G8_IE);
         chk(rd[2:0], 3'h0);
         rdr(`LSP_IDX_G8_OD);
         chk(rd[2:0], 3'h7);
         rdr(14'h0001);
         chk(rd, 32'h0);
         chk(rsp, 2'h2);
         wr(14'h0001, 8'h00);
         chk(rsp, 2'h2);
         s_axi_wstrb <= 4'h0;
         wr(`LSP_IDX_G9_OD, 8'h00);
         s_axi_wstrb <= 4'hf;
         chk(rsp, 2'h0);
         rdr(`LSP_IDX_G9_OD);
         chk(rd, 32'hff);
      end
   endtask
   task t_ref;
      begin
         // Widths just inside and just outside the accepted window
         for (w = 46; w <= 54; w = w + 1) begin
            wr(`LSP_IDX_G9_IE, 8'h00);
            @(posedge clk);
            g9_ext[1] <= 1'b1;
            repeat (w) @(posedge clk);
            g9_ext[1] <= 1'b0;
            repeat (6) @(posedge clk);
            rdr(`LSP_IDX_G9_IE);
            chk(rd[1], w >= 48 && w <= 52);
         end
      end
   endtask
   task t_drive;
      begin
         wr(`LSP_IDX_G9_OE, 8'h00);
         chk(rsp, 2'h0);
         wr(`LSP_IDX_G9_OD, 8'ha5);
         wr(`LSP_IDX_G8_OE, 8'h00);
         wr(`LSP_IDX_G8_OD, 8'h05);
         wr(`LSP_IDX_G9_IE, 8'hff);
         wr(`LSP_IDX_G8_IE, 8'h07);
         settle;
         chk({g9_pad_oe, g9_pad_out}, 16'hffa5);
         chk({g8_pad_oe, g8_pad_out}, 6'h3d);
         rdr(`LSP_IDX_G8_ID);
         chk(rd[2:0], 3'h5);
         g9_ext <= 8'h3c;
         wr(`LSP_IDX_G9_OE, 8'hff);
         rdr(`LSP_IDX_G9_ID);
         chk(rd, 32'h3c);
         wr(`LSP_IDX_G9_IE, 8'h00);
         g9_ext <= 8'hc3;
         rdr(`LSP_IDX_G9_ID);
         chk(rd, 32'h3c);
      end
   endtask
   task t_func;
      begin
         g9_sf_out <= 8'h5a;
         g9_sf_oe <= 8'hff;
         wr(`LSP_IDX_G9_FS, 8'hff);
         settle;
         chk(g9_function_sel, 8'hff);
         chk({g9_pad_oe, g9_pad_out}, 16'hff5a);
         wr(`LSP_IDX_G9_FS, 8'h00);
         settle;
         chk(g9_pad_oe, 8'h0);
      end
   endtask
   task t_serial;
      begin
         wr(`LSP_IDX_G9_IE, 8'h02);
         serial_data_out <= 1'b1;
         wr(`LSP_IDX_PWR, 8'h40);
         settle;
         chk({serial_mode, g9_pad_oe[2], g9_pad_out[2:1]}, 4'hd);
         serial_data_out <= 1'b0;
         serial_clk_out <= 1'b1;
         settle;
         chk({g9_pad_oe[2], g9_pad_out[2:1]}, 3'h6);
         wr(`LSP_IDX_PWR, 8'h00);
      end
   endtask
   task t_gate;
      begin
         wr(`LSP_IDX_G9_IE, 8'hff);
         wr(`LSP_IDX_G9_OE, 8'h00);
         wr(`LSP_IDX_G8_OE, 8'h00);
         rdr(`LSP_IDX_G9_ID);
         keep = rd;
         g9_ext <= ~keep[7:0];
         wr(`LSP_IDX_PWR, 8'h18);
         settle;
         chk({low_groups_gated, g8_pad_oe, g9_pad_oe}, 12'h800);
         rdr(`LSP_IDX_G9_ID);
         chk(rd, keep);
         wr(`LSP_IDX_PWR, 8'h00);
      end
   endtask
   task t_seg;
      begin
         g8_seg_sel <= 3'h7;
         g8_seg_val <= 3'h2;
         g9_seg_val <= 1'b1;
         wr(`LSP_IDX_G8_OE, 8'h07);
         wr(`LSP_IDX_G9_OE, 8'hff);
         wr(`LSP_IDX_G9_IE, 8'h00);
         wr(`LSP_IDX_SEG, 8'h01);
         settle;
         chk({g8_pad_out, g9_pad_out[0]}, 4'h5);
         chk({g8_pad_oe, g9_pad_oe}, 11'h701);
      end
   endtask
   task wrap_up;
      begin
         $display("Mismatches %0d of %0d compares", err_total, compares);
         if (err_total == 0 && compares > 0) $display("ALL CHECKS OK");
         else $display("CHECKS NOT OK");
         $finish;
      end
   endtask
   // Ceiling well above the roughly eight hundred cycles the scenarios need
   always @(posedge clk) begin
      cyc = cyc + 1;
      if (cyc == 20000) begin
         err_total = err_total + 1;
         wrap_up;
      end
   end
   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      t_reset;
      t_ref;
      t_drive;
      t_func;
      t_serial;
      t_gate;
      t_seg;
      wrap_up;
   end
endmodule
